// ### common/dpr_defs.vh
// Purpose: shared constants for the dual-port block memory
// Assumes: included by bare name from every file that uses its macros
// Notes:   widths are in cells; mode codes select read-during-write
`ifndef DPR_DEFS_VH
`define DPR_DEFS_VH
`define DPR_DATA_CELLS    16384
`define DPR_CHECK_CELLS   2048
`define DPR_PRELOAD_BITS  256
`define DPR_PRELOAD_WORDS 64
`define DPR_CHECK_WORDS   8
`define DPR_MODE_NEW      2'h0
`define DPR_MODE_OLD      2'h1
`define DPR_MODE_HOLD     2'h2
`define DPR_WIDTH_DEF     36
`define DPR_CLK_PERIOD_NS 100
`endif

// ### src/dpr_ctrl_pol.v
// Purpose: polarity adjust for one port's control inputs
// Assumes: inputs come from logic on the same clock
// Notes:   pure combinational, no state
`timescale 1ns/1ps
module dpr_ctrl_pol #(
  parameter INV_GATE   = 0,
  parameter INV_WRITE  = 0,
  parameter INV_PRESET = 0
) (
  // raw controls
  input  wire raw_gate,
  input  wire raw_write,
  input  wire raw_preset,
  // active-high controls
  output wire gate,
  output wire write,
  output wire preset
);
  assign gate   = (INV_GATE   != 0) ? ~raw_gate   : raw_gate;
  assign write  = (INV_WRITE  != 0) ? ~raw_write  : raw_write;
  assign preset = (INV_PRESET != 0) ? ~raw_preset : raw_preset;
endmodule

// ### src/dpr_port_out.v
// Purpose: output latch of one port
// Assumes: rd_word is the array word before this edge's write
// Notes:   global init is asynchronous and loads a constant only
`timescale 1ns/1ps
`include "dpr_defs.vh"
module dpr_port_out #(
  parameter        W        = 36,
  parameter [35:0] INIT_OUT = 36'h0,
  parameter [35:0] PRESET   = 36'h0,
  parameter [1:0]  MODE     = `DPR_MODE_NEW
) (
  // clock and init
  input  wire         clk,
  input  wire         rst_n,
  // decoded controls
  input  wire         gate,
  input  wire         write,
  input  wire         preset,
  // data
  input  wire [W-1:0] wr_word,
  input  wire [W-1:0] rd_word,
  output reg  [W-1:0] q
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= INIT_OUT[W-1:0];
    end else if (gate) begin
      if (preset) begin
        q <= PRESET[W-1:0];
      end else if (!write) begin
        q <= rd_word;
      end else begin
        case (MODE)
          `DPR_MODE_NEW:  q <= wr_word;
          `DPR_MODE_OLD:  q <= rd_word;
          `DPR_MODE_HOLD: q <= q;
          default:        q <= wr_word;
        endcase
      end
    end
  end
endmodule

// ### src/dpr_ram.v
// Purpose: true dual-port block memory, 16384 data plus 2048 check cells
// Assumes: one clock clk for both ports; rst_n is the global init signal
// Notes:   port widths 1,2,4,9,18,36; check cells need widths 9,18,36
//
// Overview of operation
// - two independent ports share one 18K-bit array
// - each port samples inputs on its clock edge, rising by default
// - inactive gate: no write, output latches hold
// - gate and write strobe active: store input word at address
// - gate active, strobe inactive: output latches load array word
// - preset loads output latches synchronously, array untouched
// - each port has its own preset value as wide as the port
// - preset acts only while gate is active
// - width sets depth and address width, 16384x1 down to 512x36
// - widths 9,18,36 split into main bus plus 1,2,4 check bits
// - read output shows word at the last sampled address
// - write shows new data or old contents according to mode
// - hold mode keeps outputs unchanged during a write
// - gate, strobe, preset and clock each have a polarity option; here clk is rising only, no clock option
// - global init loads output latches, leaves array untouched
// - word a of width w covers cells a*w to (a+1)*w-1
// - array starts zero unless preloaded, zero-padded high bits
// - 64 preload values of 256 bits cover the data cells
// - eight 256-bit check-bit preloads, mapped likewise, default zero
// - output latches take a configurable initial value, default zero
// - mode per port: new-data, old-data or hold, new by default
// - both ports writing one cell gives undefined unless data match
// - write with read on other port: old data only in old mode; here old data in every mode
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "dpr_defs.vh"
module dpr_ram #(
  parameter         WIDTH_A      = `DPR_WIDTH_DEF,
  parameter         WIDTH_B      = `DPR_WIDTH_DEF,
  parameter [1:0]   MODE_A       = `DPR_MODE_NEW,
  parameter [1:0]   MODE_B       = `DPR_MODE_NEW,
  parameter [35:0]  INIT_A       = 36'h0,
  parameter [35:0]  INIT_B       = 36'h0,
  parameter [35:0]  PRESET_A     = 36'h0,
  parameter [35:0]  PRESET_B     = 36'h0,
  parameter         INV_GATE_A   = 0,
  parameter         INV_WRITE_A  = 0,
  parameter         INV_PRESET_A = 0,
  parameter         INV_GATE_B   = 0,
  parameter         INV_WRITE_B  = 0,
  parameter         INV_PRESET_B = 0,
  parameter [16383:0] CONTENT_PRELOAD   = 16384'h0,
  parameter [2047:0]  CHECK_BIT_PRELOAD = 2048'h0
) (
  // clock and global init
  input  wire        clk,
  input  wire        rst_n,
  // port a controls
  input  wire        gate_a,
  input  wire        write_a,
  input  wire        sync_output_preset_a,
  input  wire [13:0] addr_a,
  // port a data
  input  wire [31:0] write_word_a,
  input  wire [3:0]  write_check_bits_a,
  output wire [31:0] read_word_a,
  output wire [3:0]  read_check_bits_a,
  // port b controls
  input  wire        gate_b,
  input  wire        write_b,
  input  wire        sync_output_preset_b,
  input  wire [13:0] addr_b,
  // port b data
  input  wire [31:0] write_word_b,
  input  wire [3:0]  write_check_bits_b,
  output wire [31:0] read_word_b,
  output wire [3:0]  read_check_bits_b
);
  // check bits per port: 1 per 8 data bits at widths 9,18,36
  localparam CA  = (WIDTH_A >= 9) ? WIDTH_A / 9 : 0;
  localparam CB  = (WIDTH_B >= 9) ? WIDTH_B / 9 : 0;
  localparam DA  = WIDTH_A - CA;
  localparam DB  = WIDTH_B - CB;
  localparam CAW = (CA > 0) ? CA : 1;
  localparam CBW = (CB > 0) ? CB : 1;
  // address width per width: 14 at 1 bit down to 9 at 36 bits
  localparam AWA = (DA == 1) ? 14 : (DA == 2) ? 13 : (DA == 4) ? 12 :
                   (DA == 8) ? 11 : (DA == 16) ? 10 : 9;
  localparam AWB = (DB == 1) ? 14 : (DB == 2) ? 13 : (DB == 4) ? 12 :
                   (DB == 8) ? 11 : (DB == 16) ? 10 : 9;

  // array held in flip-flops, indexed by cell number
  reg [`DPR_DATA_CELLS-1:0]  data_cells;
  reg [`DPR_CHECK_CELLS-1:0] check_cells;

  // decoded controls
  wire ga;
  wire wa;
  wire pa;
  wire gb;
  wire wb;
  wire pb;

  dpr_ctrl_pol #(
    .INV_GATE   (INV_GATE_A),
    .INV_WRITE  (INV_WRITE_A),
    .INV_PRESET (INV_PRESET_A)
  ) u_pol_a (
    .raw_gate   (gate_a),
    .raw_write  (write_a),
    .raw_preset (sync_output_preset_a),
    .gate       (ga),
    .write      (wa),
    .preset     (pa)
  );

  dpr_ctrl_pol #(
    .INV_GATE   (INV_GATE_B),
    .INV_WRITE  (INV_WRITE_B),
    .INV_PRESET (INV_PRESET_B)
  ) u_pol_b (
    .raw_gate   (gate_b),
    .raw_write  (write_b),
    .raw_preset (sync_output_preset_b),
    .gate       (gb),
    .write      (wb),
    .preset     (pb)
  );

  // address kept to the port's depth; a mask, not a zero field,
  // so a port using all 14 address bits needs no empty replication
  wire [13:0] mask_a = ~(14'h3fff << AWA);
  wire [13:0] mask_b = ~(14'h3fff << AWB);
  wire [13:0] ia     = addr_a & mask_a;
  wire [13:0] ib     = addr_b & mask_b;

  // old array words as read before this edge's writes
  wire [DA-1:0]  rd_data_a  = data_cells[ia*DA +: DA];
  wire [DB-1:0]  rd_data_b  = data_cells[ib*DB +: DB];
  wire [CAW-1:0] rd_check_a = (CA > 0) ?
                              check_cells[ia*CAW +: CAW] :
                              {CAW{1'b0}};
  wire [CBW-1:0] rd_check_b = (CB > 0) ?
                              check_cells[ib*CBW +: CBW] :
                              {CBW{1'b0}};

  wire [CAW+DA-1:0] rd_a = {rd_check_a, rd_data_a};
  wire [CBW+DB-1:0] rd_b = {rd_check_b, rd_data_b};
  wire [CAW+DA-1:0] wr_a = {write_check_bits_a[CAW-1:0],
                            write_word_a[DA-1:0]};
  wire [CBW+DB-1:0] wr_b = {write_check_bits_b[CBW-1:0],
                            write_word_b[DB-1:0]};

  // array is not cleared by the global init; preload is its start
  initial begin
    data_cells  = CONTENT_PRELOAD;
    check_cells = CHECK_BIT_PRELOAD;
  end

  // writes; on a same-cell collision port b lands last, the user
  // must avoid that case since the result is not defined
  always @(posedge clk) begin
    if (ga && wa) begin
      data_cells[ia*DA +: DA] <= write_word_a[DA-1:0];
      if (CA > 0) begin
        check_cells[ia*CAW +: CAW] <= write_check_bits_a[CAW-1:0];
      end
    end
    if (gb && wb) begin
      data_cells[ib*DB +: DB] <= write_word_b[DB-1:0];
      if (CB > 0) begin
        check_cells[ib*CBW +: CBW] <= write_check_bits_b[CBW-1:0];
      end
    end
  end

  // output latches; reads see the pre-edge array, so a cross-port
  // read during a write returns old contents in every mode
  wire [CAW+DA-1:0] q_a;
  wire [CBW+DB-1:0] q_b;

  dpr_port_out #(
    .W        (CAW+DA),
    .INIT_OUT (INIT_A),
    .PRESET   (PRESET_A),
    .MODE     (MODE_A)
  ) u_out_a (
    .clk     (clk),
    .rst_n   (rst_n),
    .gate    (ga),
    .write   (wa),
    .preset  (pa),
    .wr_word (wr_a),
    .rd_word (rd_a),
    .q       (q_a)
  );

  dpr_port_out #(
    .W        (CBW+DB),
    .INIT_OUT (INIT_B),
    .PRESET   (PRESET_B),
    .MODE     (MODE_B)
  ) u_out_b (
    .clk     (clk),
    .rst_n   (rst_n),
    .gate    (gb),
    .write   (wb),
    .preset  (pb),
    .wr_word (wr_b),
    .rd_word (rd_b),
    .q       (q_b)
  );

  // buses split, unused high bits read zero; built bit by bit so
  // a full-width port needs no empty zero field
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_word
      if (i < DA) begin : g_used_a
        assign read_word_a[i] = q_a[i];
      end else begin : g_free_a
        assign read_word_a[i] = 1'b0;
      end
      if (i < DB) begin : g_used_b
        assign read_word_b[i] = q_b[i];
      end else begin : g_free_b
        assign read_word_b[i] = 1'b0;
      end
    end
    for (i = 0; i < 4; i = i + 1) begin : g_check
      if (i < CA) begin : g_used_a
        assign read_check_bits_a[i] = q_a[DA+i];
      end else begin : g_free_a
        assign read_check_bits_a[i] = 1'b0;
      end
      if (i < CB) begin : g_used_b
        assign read_check_bits_b[i] = q_b[DB+i];
      end else begin : g_free_b
        assign read_check_bits_b[i] = 1'b0;
      end
    end
  endgenerate
endmodule

// ### test/dpr_ram_monitor.sv
// Purpose: port-level checks on the dual-port memory
// Assumes: port a width 36, port b width 9, any write modes
// Notes:   sees top ports only; bound onto dpr_ram
`timescale 1ns/1ps
`include "dpr_defs.vh"
module dpr_ram_monitor #(
  parameter [35:0] INIT_A   = 36'h0,
  parameter [35:0] PRESET_A = 36'h0,
  parameter [35:0] PRESET_B = 36'h0,
  parameter [1:0]  MODE_A   = `DPR_MODE_NEW,
  parameter [1:0]  MODE_B   = `DPR_MODE_NEW
) (
  // clock and init
  input wire        clk,
  input wire        rst_n,
  // port a
  input wire        gate_a,
  input wire        write_a,
  input wire        sync_output_preset_a,
  input wire [31:0] write_word_a,
  input wire [3:0]  write_check_bits_a,
  input wire [31:0] read_word_a,
  input wire [3:0]  read_check_bits_a,
  // port b
  input wire        gate_b,
  input wire        write_b,
  input wire        sync_output_preset_b,
  input wire [31:0] write_word_b,
  input wire [3:0]  write_check_bits_b,
  input wire [31:0] read_word_b,
  input wire [3:0]  read_check_bits_b
);
  // mode flags keep each write check to the instances it fits
  localparam bit A_NEW  = (MODE_A == `DPR_MODE_NEW);
  localparam bit B_NEW  = (MODE_B == `DPR_MODE_NEW);
  localparam bit B_HOLD = (MODE_B == `DPR_MODE_HOLD);
  wire [35:0] out_a  = {read_check_bits_a, read_word_a};
  wire [35:0] out_b  = {read_check_bits_b, read_word_b};
  wire [35:0] in_a   = {write_check_bits_a, write_word_a};
  // port b seen as 9 bits: 8 data plus 1 check bit
  wire [35:0] in_b9  = {3'h0, write_check_bits_b[0], 24'h0,
                        write_word_b[7:0]};
  wire [35:0] pre_b9 = {3'h0, PRESET_B[8], 24'h0, PRESET_B[7:0]};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_preset_a;
    gate_a && sync_output_preset_a;
  endsequence
  sequence s_write_a;
    gate_a && write_a && !sync_output_preset_a;
  endsequence
  sequence s_write_b;
    gate_b && write_b && !sync_output_preset_b;
  endsequence
  sequence s_preset_b;
    gate_b && sync_output_preset_b;
  endsequence
  chk_gate_hold_a: assert property (!gate_a |=> $stable(out_a))
    else $error("port a output moved with gate low");
  chk_gate_hold_b: assert property (!gate_b |=> $stable(out_b))
    else $error("port b output moved with gate low");
  chk_preset_a: assert property (
    s_preset_a |=> out_a == PRESET_A)
    else $error("port a preset value wrong");
  chk_preset_b: assert property (
    s_preset_b |=> out_b == pre_b9)
    else $error("port b preset value wrong");
  chk_new_data_a: assert property (
    s_write_a ##0 A_NEW |=> out_a == $past(in_a))
    else $error("port a write did not show new data");
  chk_new_data_b: assert property (
    s_write_b ##0 B_NEW |=> out_b == $past(in_b9))
    else $error("port b write did not show new data");
  chk_hold_write_b: assert property (
    s_write_b ##0 B_HOLD |=> $stable(out_b))
    else $error("port b output moved during hold write");
  chk_narrow_b: assert property (
    out_b[35:33] == 3'h0 && out_b[31:8] == 24'h0)
    else $error("port b unused output bits set");
  chk_init_out_a: assert property (disable iff (1'b0)
    !rst_n |-> out_a == INIT_A)
    else $error("port a output not initial value in init");
endmodule
bind dpr_ram dpr_ram_monitor #(
  .INIT_A(INIT_A), .PRESET_A(PRESET_A), .PRESET_B(PRESET_B),
  .MODE_A(MODE_A), .MODE_B(MODE_B)
) mon (.clk, .rst_n, .gate_a, .write_a, .sync_output_preset_a,
  .write_word_a, .write_check_bits_a, .read_word_a, .read_check_bits_a,
  .gate_b, .write_b, .sync_output_preset_b, .write_word_b,
  .write_check_bits_b, .read_word_b, .read_check_bits_b);

// ### test/dpr_ram_test.sv
// Purpose: self-checking bench for the dual-port memory
// Assumes: dut a new/b hold, twin a old/b new; 36 and 9 bits
// Notes:   idle ports keep outputs, so checks run 1ns after the op's edge
`timescale 1ns/1ps
`include "dpr_defs.vh"
module dpr_ram_test;
  localparam [35:0] IA = 36'h0000000c3;
  localparam [35:0] IB = 36'h000000111;
  localparam [35:0] PA = 36'h987654321;
  localparam [35:0] PB = 36'h0000001a5;
  localparam [35:0] OB0 = 36'h100000011;
  localparam [35:0] OBB = 36'h1000000bb;
  localparam [35:0] OPB = 36'h1000000a5;
  reg         clk = 1'b0;
  reg         rst_n = 1'b1;
  integer     n_errors = 0;
  integer     checked = 0;
  wire        ga, wa, pa, gb, wb, pb;
  wire [13:0] aa, ab;
  wire [31:0] da, db, qa, qb;
  wire [3:0]  ca, cb, ka, kb;
  wire [31:0] qa2, qb2;
  wire [3:0]  ka2, kb2;
  always #50 clk = ~clk;
  dpr_user ua (.clk(clk), .gate(ga), .write(wa), .preset(pa),
    .addr(aa), .word(da), .check(ca));
  dpr_user ub (.clk(clk), .gate(gb), .write(wb), .preset(pb),
    .addr(ab), .word(db), .check(cb));
  dpr_ram #(.WIDTH_A(36), .WIDTH_B(9), .MODE_B(`DPR_MODE_HOLD),
    .INIT_A(IA), .INIT_B(IB), .PRESET_A(PA), .PRESET_B(PB),
    .CONTENT_PRELOAD(16384'hab << 256),
    .CHECK_BIT_PRELOAD(2048'h3 << 4)) dut (.clk(clk), .rst_n(rst_n),
    .gate_a(ga), .write_a(wa), .sync_output_preset_a(pa), .addr_a(aa),
    .write_word_a(da), .write_check_bits_a(ca), .read_word_a(qa),
    .read_check_bits_a(ka), .gate_b(gb), .write_b(wb),
    .sync_output_preset_b(pb), .addr_b(ab), .write_word_b(db),
    .write_check_bits_b(cb), .read_word_b(qb), .read_check_bits_b(kb));
  // twin array with port a in old-data mode and port b in new-data mode
  dpr_ram #(.WIDTH_A(36), .WIDTH_B(9), .MODE_A(`DPR_MODE_OLD),
    .MODE_B(`DPR_MODE_NEW), .INIT_A(IA), .INIT_B(IB), .PRESET_A(PA),
    .PRESET_B(PB), .CONTENT_PRELOAD(16384'hab << 256),
    .CHECK_BIT_PRELOAD(2048'h3 << 4)) dut_alt (.clk(clk), .rst_n(rst_n),
    .gate_a(ga), .write_a(wa), .sync_output_preset_a(pa), .addr_a(aa),
    .write_word_a(da), .write_check_bits_a(ca), .read_word_a(qa2),
    .read_check_bits_a(ka2), .gate_b(gb), .write_b(wb),
    .sync_output_preset_b(pb), .addr_b(ab), .write_word_b(db),
    .write_check_bits_b(cb), .read_word_b(qb2), .read_check_bits_b(kb2));
  task cmp(input string nm, input [35:0] e, g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // park both ports, compare outputs, realign to an edge
  task chk(input [35:0] ea, eb, ea2, eb2);
    ua.idle();
    ub.idle();
    #1;
    cmp("port a out", ea, {ka, qa});
    cmp("port b out", eb, {kb, qb});
    cmp("twin port a out", ea2, {ka2, qa2});
    cmp("twin port b out", eb2, {kb2, qb2});
    @(posedge clk);
  endtask
  task final_report;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    final_report;
  end
  // no same-cell writes from both ports on one edge
  initial begin
    rst_n <= 1'b0;
    @(posedge clk);
    chk(IA, OB0, IA, OB0);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    ua.op(1, 0, 0, 14'd8, 0);
    chk(36'h0000000ab, OB0, 36'h0000000ab, OB0);
    ua.op(1, 0, 0, 14'd1, 0);
    chk(36'h300000000, OB0, 36'h300000000, OB0);
    fork
      ua.op(1, 1, 0, 14'd2, 36'haddccbbaa);
      ub.op(0, 1, 0, 14'd9, 0);
    join
    chk(36'haddccbbaa, OB0, 36'h000000000, OB0);
    ub.op(1, 0, 0, 14'd9, 0);
    chk(36'haddccbbaa, OBB, 36'h000000000, OBB);
    ub.op(1, 1, 0, 14'd9, 36'h77);
    chk(36'haddccbbaa, OBB, 36'h000000000, 36'h000000077);
    ua.op(1, 0, 0, 14'd2, 0);
    chk(36'h8ddcc77aa, OBB, 36'h8ddcc77aa, 36'h000000077);
    ua.op(0, 0, 1, 14'd2, 0);
    chk(36'h8ddcc77aa, OBB, 36'h8ddcc77aa, 36'h000000077);
    fork
      ua.op(1, 0, 1, 14'd8, 0);
      ub.op(1, 1, 0, 14'd16, 36'h10000003c);
    join
    chk(PA, OBB, PA, 36'h10000003c);
    fork
      ua.op(1, 0, 0, 14'd8, 0);
      ub.op(1, 0, 1, 14'd0, 0);
    join
    chk(36'h0000000ab, OPB, 36'h0000000ab, OPB);
    ua.op(1, 0, 0, 14'd4, 0);
    chk(36'h10000003c, OPB, 36'h10000003c, OPB);
    rst_n <= 1'b0;
    chk(IA, OB0, IA, OB0);
    rst_n <= 1'b1;
    ua.op(1, 0, 0, 14'd4, 0);
    chk(36'h10000003c, OB0, 36'h10000003c, OB0);
    final_report;
  end
endmodule

// ### test/dpr_user.sv
// Purpose: user logic driving one memory port
// Assumes: tasks called by the bench at a rising edge
// Notes:   idle parks address and data high, not floating
`timescale 1ns/1ps
module dpr_user (
  // clock
  input  wire        clk,
  // port controls
  output reg         gate,
  output reg         write,
  output reg         preset,
  output reg  [13:0] addr,
  // port data
  output reg  [31:0] word,
  output reg  [3:0]  check
);
  task automatic idle();
    gate <= 1'b0;
    write <= 1'b0;
    preset <= 1'b0;
    addr <= 14'h3fff;
    {check, word} <= 36'hf_ffff_ffff;
  endtask
  // one access held until the sampling edge
  task automatic op(input g, w, p, input [13:0] a, input [35:0] d);
    gate <= g;
    write <= w;
    preset <= p;
    addr <= a;
    {check, word} <= d;
    @(posedge clk);
  endtask
  initial idle();
endmodule
